// File: logic/lrd_core.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1 - config-load word copies whole accumulator into prescaler config, no flag change
// RULE2 - return-with-literal loads its low 8 bits into accumulator, flags kept
// RULE3 - return-with-literal reloads program counter from stack top
// RULE4 - return-with-literal takes two cycles; prefetched word is discarded
// RULE5 - rotate-left-through-carry opcode is recognised by the decoder
// RULE6 - all-zero word is one-cycle idle that only advances the counter
module lrd_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic insn_valid,
    input wire logic [lrd_pkg::INSN_W-1:0] insn,
    input wire logic [lrd_pkg::PC_W-1:0] stack_top,
    output logic [lrd_pkg::DATA_W-1:0] acc,
    output logic [lrd_pkg::DATA_W-1:0] cfg,
    output logic [lrd_pkg::PC_W-1:0] pc,
    output logic stack_pop,
    output logic flush,
    output logic rot_left_carry,
    output logic idle_instruction
);
    import lrd_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {
        LRD_RUN = 2'b01,
        LRD_FLUSH = 2'b10
    } lrd_state_e;

    // pulses sit in the state word too, so every output leaves a flop
    typedef struct packed {
        lrd_state_e st;
        logic [7:0] acc;
        logic [7:0] cfg;
        logic [9:0] pc;
        logic pop;
        logic flush;
        logic rot;
        logic idle;
    } lrd_state_s;

    lrd_state_s s_reg;
    lrd_state_s s_next;
    logic d_idle;
    logic d_cfg;
    logic d_ret;
    logic d_rot;
    logic [7:0] d_lit;

    // ****************************************
    // decode
    // ****************************************
    // one decoder feeds both the execute path and the checks below
    lrd_decode u_lrd_decode (
        .insn(insn),
        .is_idle(d_idle),
        .is_cfg_load(d_cfg),
        .is_ret_lit(d_ret),
        .is_rot_left(d_rot),
        .literal(d_lit)
    );

    // ****************************************
    // execute
    // ****************************************
    // one word is executed per taken edge and shows one cycle later; a
    // taken return costs a second edge while the fetch path refills, and
    // whatever it presents in that edge is thrown away
    always_comb begin
        s_next = s_reg;
        s_next.pop = 1'b0;
        s_next.flush = 1'b0;
        s_next.rot = 1'b0;
        s_next.idle = 1'b0;
        case (s_reg.st)
            LRD_RUN: begin
                if (insn_valid) begin
                    // counter wraps from its top address to zero; paging lives elsewhere
                    s_next.pc = s_reg.pc + 10'h001;
                    s_next.rot = d_rot;
                    s_next.idle = d_idle;
                    // RULE1 accumulator to config
                    if (d_cfg) begin
                        s_next.cfg = s_reg.acc;
                    end
                    if (d_ret) begin
                        // RULE2 literal into accumulator
                        s_next.acc = d_lit;
                        // RULE3 counter from stack top
                        s_next.pc = stack_top;
                        s_next.pop = 1'b1;
                        // RULE4 second cycle discards
                        s_next.flush = 1'b1;
                        s_next.st = LRD_FLUSH;
                    end
                end
            end
            LRD_FLUSH: begin
                // prefetched word dropped; fetch restarts at the return address.
                // insn_valid is ignored on purpose: the fetch path may still flag
                // the stale word as valid, and executing it would corrupt state
                s_next.st = LRD_RUN;
            end
            default: s_next.st = LRD_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{
                st: LRD_RUN,
                acc: ACC_RST,
                cfg: CFG_RST,
                pc: PC_RST,
                pop: 1'b0,
                flush: 1'b0,
                rot: 1'b0,
                idle: 1'b0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign acc = s_reg.acc;
    assign cfg = s_reg.cfg;
    assign pc = s_reg.pc;
    assign stack_pop = s_reg.pop;
    assign flush = s_reg.flush;
    assign rot_left_carry = s_reg.rot;
    assign idle_instruction = s_reg.idle;

    // ****************************************
    // checks
    // ****************************************
    // antecedents use the decoder's flags, the raw word or the outputs; consequents are written against
    // the outputs except in rot_only_a and idle_only_a, so a broken register path is still caught
    cfg_copy_a: assert property (@(posedge clk) disable iff (rst) // RULE1
        (s_reg.st == LRD_RUN && insn_valid && d_cfg) |=> (cfg == $past(acc)))
        else $error("config not loaded from accumulator");
    lit_load_a: assert property (@(posedge clk) disable iff (rst) // RULE2
        (s_reg.st == LRD_RUN && insn_valid && d_ret) |=> (acc == $past(insn[7:0])))
        else $error("literal not in accumulator");
    pc_reload_a: assert property (@(posedge clk) disable iff (rst) // RULE3
        (s_reg.st == LRD_RUN && insn_valid && d_ret) |=> (pc == $past(stack_top) && stack_pop))
        else $error("counter not reloaded from stack top");
    two_cycle_a: assert property (@(posedge clk) disable iff (rst) // RULE4
        (s_reg.st == LRD_RUN && insn_valid && d_ret) |=> flush ##1 (!flush && $stable(pc)))
        else $error("return not two cycles");
    rot_seen_a: assert property (@(posedge clk) disable iff (rst) // RULE5
        (s_reg.st == LRD_RUN && insn_valid && insn[11:6] == 6'h0d) |=> rot_left_carry)
        else $error("rotate opcode missed");
    idle_step_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        (s_reg.st == LRD_RUN && insn_valid && insn == 12'h000)
        |=> (pc == $past(pc) + 10'h001 && $stable(acc) && $stable(cfg) && !stack_pop))
        else $error("idle word changed state");
    cfg_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE1
        !(s_reg.st == LRD_RUN && insn_valid && d_cfg) |=> $stable(cfg))
        else $error("config changed without load");
    flush_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE4
        flush |=> !stack_pop)
        else $error("discarded word executed");
    acc_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE2
        !(s_reg.st == LRD_RUN && insn_valid && d_ret) |=> $stable(acc))
        else $error("accumulator changed without return");
    ret_no_cfg_a: assert property (@(posedge clk) disable iff (rst) // RULE2
        (s_reg.st == LRD_RUN && insn_valid && d_ret) |=> $stable(cfg))
        else $error("return changed the config register");
    discard_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE4
        flush |=> ($stable(acc) && $stable(cfg) && $stable(pc)))
        else $error("discarded word changed state");
    discard_quiet_a: assert property (@(posedge clk) disable iff (rst) // RULE4
        flush |=> (!flush && !rot_left_carry && !idle_instruction))
        else $error("discarded word raised a pulse");
    pop_pair_a: assert property (@(posedge clk) disable iff (rst) // RULE3
        stack_pop == flush)
        else $error("stack pop and discard out of step");
    pop_once_a: assert property (@(posedge clk) disable iff (rst) // RULE3
        stack_pop |=> !stack_pop)
        else $error("stack popped twice for one return");
    pc_step_a: assert property (@(posedge clk) disable iff (rst) // RULE3
        (s_reg.st == LRD_RUN && insn_valid && !d_ret)
        |=> (pc == $past(pc) + 10'h001))
        else $error("counter reloaded without return");
    rot_only_a: assert property (@(posedge clk) disable iff (rst) // RULE5
        rot_left_carry |-> ($past(insn_valid) && $past(insn[11:6]) == 6'h0d))
        else $error("rotate pulse without rotate opcode");
    rot_keep_a: assert property (@(posedge clk) disable iff (rst) // RULE5
        (s_reg.st == LRD_RUN && insn_valid && d_rot)
        |=> ($stable(acc) && $stable(cfg) && !stack_pop))
        else $error("rotate recognition changed state");
    idle_only_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        idle_instruction |-> ($past(insn_valid) && $past(insn) == 12'h000))
        else $error("idle pulse without zero word");
    idle_quiet_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        (s_reg.st == LRD_RUN && insn_valid && d_idle) |=> (!rot_left_carry && !flush))
        else $error("idle word raised another pulse");
    cfg_step_a: assert property (@(posedge clk) disable iff (rst) // RULE1
        (s_reg.st == LRD_RUN && insn_valid && d_cfg)
        |=> (pc == $past(pc) + 10'h001 && $stable(acc) && !stack_pop))
        else $error("config load not a single step");
    pc_wait_a: assert property (@(posedge clk) disable iff (rst) // RULE6
        (s_reg.st == LRD_RUN && !insn_valid) |=> $stable(pc))
        else $error("counter moved without a word");

    // ****************************************
    // coverage
    // ****************************************
    ret_c: cover property (@(posedge clk) disable iff (rst)
        s_reg.st == LRD_RUN && insn_valid && d_ret);
    cfg_c: cover property (@(posedge clk) disable iff (rst)
        s_reg.st == LRD_RUN && insn_valid && d_cfg);
    idle_c: cover property (@(posedge clk) disable iff (rst) idle_instruction);
    rot_c: cover property (@(posedge clk) disable iff (rst) rot_left_carry);
    discard_c: cover property (@(posedge clk) disable iff (rst)
        flush && insn_valid);
endmodule : lrd_core
`default_nettype wire

// File: logic/lrd_decode.sv
`timescale 1ns/100ps
`default_nettype none
module lrd_decode (
    input wire logic [lrd_pkg::INSN_W-1:0] insn,
    output logic is_idle,
    output logic is_cfg_load,
    output logic is_ret_lit,
    output logic is_rot_left,
    output logic [lrd_pkg::DATA_W-1:0] literal
);
    import lrd_pkg::*;
    always_comb begin
        // RULE6 zero word idle
        is_idle = (insn == OP_IDLE);
        // RULE1 config load decode
        is_cfg_load = (insn == OP_CFG_LOAD);
        // RULE2 return literal decode
        is_ret_lit = (insn[11:8] == OP_RETLIT_HI);
        // RULE5 rotate opcode match
        is_rot_left = (insn[11:6] == OP_ROT_HI);
        literal = insn[LIT_MSB:0];
    end
endmodule : lrd_decode
`default_nettype wire

// File: logic/lrd_pkg.sv
`default_nettype none
package lrd_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int PC_W = 10;
    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [11:0] OP_IDLE = 12'h000;
    localparam logic [11:0] OP_CFG_LOAD = 12'h002;
    localparam logic [3:0] OP_RETLIT_HI = 4'h8;
    localparam logic [5:0] OP_ROT_HI = 6'h0d;
    localparam int LIT_MSB = 7;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'hff;
    localparam logic [9:0] PC_RST = 10'h3ff;
    localparam logic [1:0] RET_CYCLES = 2'h2;
endpackage : lrd_pkg
`default_nettype wire

// File: verif/literal_return_option_decode_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module literal_return_option_decode_tb_top;
    import lrd_pkg::*;
    logic clk, rst, insn_valid, stack_pop, flush, rot_left_carry, idle_instruction;
    logic [11:0] insn;
    logic [9:0] stack_top, pc, p;
    logic [7:0] acc, cfg, a, c;
    int bad_count = 0;
    int cmp_count = 0;
    lrd_core u_lrd_core (.clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn),
        .stack_top(stack_top), .acc(acc), .cfg(cfg), .pc(pc), .stack_pop(stack_pop),
        .flush(flush), .rot_left_carry(rot_left_carry), .idle_instruction(idle_instruction));
    // ****************************************
    // drive and compare
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_pulses(input logic [3:0] exp);
        chk({6'h0, stack_pop, flush, rot_left_carry, idle_instruction}, {6'h0, exp});
    endtask : chk_pulses
    task automatic chk_regs(input logic [15:0] got, input logic [15:0] exp);
        chk({2'h0, got[15:8]}, {2'h0, exp[15:8]});
        chk({2'h0, got[7:0]}, {2'h0, exp[7:0]});
    endtask : chk_regs
    // inputs move 1 ns after the edge, checks land after the edge's updates
    task automatic step(input logic v, input logic [11:0] w, input logic [9:0] st);
        insn_valid = v;
        insn = w;
        stack_top = st;
        a = acc;
        c = cfg;
        p = pc;
        @(posedge clk);
        #1;
    endtask : step
    task automatic finish_test;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset;
        chk({2'h0, acc}, 10'h000);
        chk({2'h0, cfg}, 10'h0ff);
        chk(pc, 10'h3ff);
        chk_pulses(4'h0);
    endtask : test_reset
    task automatic test_idle;
        step(1'b1, OP_IDLE, 10'h0);
        chk(pc, p + 10'h1);
        chk_regs({cfg, acc}, {c, a});
        chk_pulses(4'h1);
        step(1'b0, OP_IDLE, 10'h0);
        chk_pulses(4'h0);
    endtask : test_idle
    task automatic test_return(input logic [7:0] k, input logic [9:0] st);
        step(1'b1, {OP_RETLIT_HI, k}, st);
        chk({2'h0, acc}, {2'h0, k});
        chk(pc, st);
        chk_pulses(4'hc);
        // a config load offered in each discard cycle must vanish
        repeat (int'(RET_CYCLES) - 1) begin
            step(1'b1, OP_CFG_LOAD, ~st);
            chk(pc, st);
            chk_regs({cfg, acc}, {c, k});
            chk_pulses(4'h0);
        end
    endtask : test_return
    task automatic test_cfg;
        step(1'b1, OP_CFG_LOAD, 10'h0);
        chk_regs({cfg, acc}, {a, a});
        chk(pc, p + 10'h1);
        chk_pulses(4'h0);
    endtask : test_cfg
    task automatic test_rot;
        step(1'b1, {OP_ROT_HI, 6'h2a}, 10'h0);
        chk_pulses(4'h2);
        chk(pc, p + 10'h1);
        chk_regs({cfg, acc}, {c, a});
    endtask : test_rot
    task automatic test_mid_reset;
        step(1'b1, {OP_RETLIT_HI, 8'h3c}, 10'h0aa);
        step(1'b0, OP_IDLE, 10'h000);
        step(1'b1, OP_CFG_LOAD, 10'h000);
        step(1'b1, {OP_RETLIT_HI, 8'hc3}, 10'h0aa);
        chk_regs({cfg, acc}, {8'h3c, 8'hc3});
        // reset lands in the discard cycle and must drop the pending pulses
        rst = 1'b1;
        step(1'b0, OP_IDLE, 10'h000);
        chk_regs({cfg, acc}, {CFG_RST, ACC_RST});
        chk(pc, PC_RST);
        chk_pulses(4'h0);
        rst = 1'b0;
    endtask : test_mid_reset
    initial begin
        rst = 1'b1;
        insn_valid = 1'b0;
        insn = 12'h000;
        stack_top = 10'h000;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        test_reset();
        test_idle();
        test_return(8'h00, 10'h155);
        test_cfg();
        test_return(8'hff, 10'h3ff);
        test_return(8'h5a, 10'h3ff);
        test_return(8'hff, 10'h3ff);
        test_cfg();
        test_rot();
        test_mid_reset();
        test_idle();
        finish_test();
    end
endmodule : literal_return_option_decode_tb_top
`default_nettype wire
